// ### hw/ref_switch_ramp_status.sv
`timescale 1ns/1ps
`include "rs_params.svh"
module ref_switch_ramp_status (
  // Clock and reset.
  input  wire logic           hclk,
  input  wire logic           hresetn,
  // AHB-Lite slave port.
  input  wire logic           hsel,
  input  wire rs_pkg::word_t  haddr,
  input  wire logic [1:0]     htrans,
  input  wire logic           hwrite,
  input  wire logic [2:0]     hsize,
  input  wire rs_pkg::word_t  hwdata,
  input  wire logic           hready,
  output logic                hreadyout,
  output logic                hresp,
  output rs_pkg::word_t       hrdata,
  // Reference switch pins.
  input  wire logic           left_switch_in,
  input  wire logic           right_switch_in,
  // Ramp generator state on the same clock.
  input  wire rs_pkg::word_t  actual_position,
  input  wire rs_pkg::word_t  target_position,
  input  wire rs_pkg::word_t  actual_velocity,
  input  wire rs_pkg::word_t  max_velocity,
  input  wire logic           stall_detect,
  input  wire logic           second_move_pulse,
  input  wire logic           ramp_hold_mode,
  input  wire logic           move_dir_neg,
  // Motion control and interrupt.
  output logic                motor_stop,
  output logic                standstill_hold,
  output logic                irq
);
  import rs_pkg::*;

  switch_if sw ();

  logic [`CFG_W-1:0]     switch_mode_config_r;
  logic [`WAIT_W-1:0]    standstill_wait_time_r;
  logic [`WAIT_W-1:0]    wait_cnt_r;
  logic [`WAIT_W-1:0]    wait_cnt_nxt;
  logic [`INT_W-1:0]     int_status_r;
  logic [`INT_W-1:0]     int_enable_r;
  logic [`INT_W-1:0]     int_set;
  word_t                 latched_position_r;
  word_t                 hrdata_r;
  word_t                 rd_word;
  word_t                 status_word;
  logic [`ADDR_W-1:0]    ph_addr_r;
  logic                  ph_write_r;
  logic                  hreadyout_r;
  logic                  hresp_r;
  logic                  irq_r;
  logic                  motor_stop_r;
  logic                  standstill_hold_r;
  logic                  second_move_r;
  logic                  ev_pos_r;
  logic                  stall_halt_event_r;
  logic                  stop_l_flag_r;
  logic                  stop_r_flag_r;
  logic                  latch_l_r;
  logic                  latch_r_r;
  logic                  pos_eq_q_r;
  logic                  vzero_q_r;
  logic                  take;
  logic                  rd_take;
  logic                  wr_en;
  logic                  status_read;
  logic                  pos_eq;
  logic                  vel_eq;
  logic                  vzero;
  logic                  pos_set;
  logic                  stall_set;
  logic                  latch_l_set;
  logic                  latch_r_set;
  logic                  stop_l_cond;
  logic                  stop_r_cond;
  logic                  stop_l_set;
  logic                  stop_r_set;
  logic                  stop_l_clr;
  logic                  stop_r_clr;

  switch_front u_front (
    .hclk            (hclk),
    .hresetn         (hresetn),
    .left_switch_in  (left_switch_in),
    .right_switch_in (right_switch_in),
    .sw              (sw.front)
  );

  assign sw.exchange = switch_mode_config_r[`SW_EXCHANGE];
  assign sw.pol_l = switch_mode_config_r[`SW_POL_L];
  assign sw.pol_r = switch_mode_config_r[`SW_POL_R];

  // Bus decode. Only whole-word transfers are taken; others complete without effect.
  assign take = hsel & htrans[1] & hready & (hsize == `HSIZE_WORD);
  assign rd_take = take & ~hwrite;
  assign wr_en = ph_write_r & hready;
  assign status_read = rd_take & (haddr[`ADDR_W-1:0] == `OFS_STATUS);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_write_r <= 1'h0;
      ph_addr_r <= 8'h00;
    end else if (hready) begin
      ph_write_r <= take & hwrite;
      ph_addr_r <= haddr[`ADDR_W-1:0];
    end
  end

  // After the first clock out of reset the slave never inserts wait states; it always answers OKAY.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_r <= 1'h0;
      hresp_r <= 1'h0;
    end else begin
      hreadyout_r <= 1'h1;
      hresp_r <= 1'h0;
    end
  end

  // Software registers.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      switch_mode_config_r <= `CFG_RST;
      standstill_wait_time_r <= `WAIT_RST;
      int_enable_r <= `INT_RST;
    end else if (wr_en) begin
      if (ph_addr_r == `OFS_SWITCH_CFG) begin
        switch_mode_config_r <= hwdata[`CFG_W-1:0];
      end
      if (ph_addr_r == `OFS_WAIT_TIME) begin
        standstill_wait_time_r <= hwdata[`WAIT_W-1:0];
      end
      if (ph_addr_r == `OFS_INT_ENABLE) begin
        int_enable_r <= hwdata[`INT_W-1:0];
      end
    end
  end

  // Live comparisons against the ramp generator.
  assign pos_eq = (actual_position == target_position);
  assign vel_eq = (actual_velocity == max_velocity);
  assign vzero = (actual_velocity == 32'h0000_0000);
  assign pos_set = pos_eq & ~pos_eq_q_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pos_eq_q_r <= 1'h0;
      vzero_q_r <= 1'h1;
    end else begin
      pos_eq_q_r <= pos_eq;
      vzero_q_r <= vzero;
    end
  end

  // Position latch on selected switch edges.
  assign latch_r_set = (switch_mode_config_r[`SW_LATCH_R_INACT] & sw.inact_edge[1])
                     | (switch_mode_config_r[`SW_LATCH_R_ACT] & sw.act_edge[1]);
  assign latch_l_set = (switch_mode_config_r[`SW_LATCH_L_INACT] & sw.inact_edge[0])
                     | (switch_mode_config_r[`SW_LATCH_L_ACT] & sw.act_edge[0]);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      latched_position_r <= 32'h0000_0000;
    end else if (latch_r_set | latch_l_set) begin
      latched_position_r <= actual_position;
    end
  end

  // Sticky flags. An event in the cycle of the clearing read wins.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      latch_l_r <= 1'h0;
      latch_r_r <= 1'h0;
    end else begin
      latch_l_r <= (latch_l_r & ~status_read) | latch_l_set;
      latch_r_r <= (latch_r_r & ~status_read) | latch_r_set;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      second_move_r <= 1'h0;
      ev_pos_r <= 1'h0;
    end else begin
      second_move_r <= (second_move_r & ~status_read) | second_move_pulse;
      ev_pos_r <= (ev_pos_r & ~status_read) | pos_set;
    end
  end

  // Stall stop. Disabling the function also releases the motor.
  assign stall_set = stall_detect & switch_mode_config_r[`SW_STALL_HALT_EN];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stall_halt_event_r <= 1'h0;
    end else begin
      stall_halt_event_r <= (stall_halt_event_r & ~status_read
                            & switch_mode_config_r[`SW_STALL_HALT_EN]) | stall_set;
    end
  end

  // Switch stops. A switch only stops motion heading towards it.
  assign stop_r_cond = switch_mode_config_r[`SW_STOP_R_EN] & sw.active[1];
  assign stop_l_cond = switch_mode_config_r[`SW_STOP_L_EN] & sw.active[0];
  assign stop_r_set = stop_r_cond & ~move_dir_neg & ~ramp_hold_mode;
  assign stop_l_set = stop_l_cond & move_dir_neg & ~ramp_hold_mode;
  assign stop_r_clr = ramp_hold_mode | move_dir_neg | ~switch_mode_config_r[`SW_STOP_R_EN];
  assign stop_l_clr = ramp_hold_mode | ~move_dir_neg | ~switch_mode_config_r[`SW_STOP_L_EN];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stop_r_flag_r <= 1'h0;
      stop_l_flag_r <= 1'h0;
    end else begin
      stop_r_flag_r <= (stop_r_flag_r & ~stop_r_clr) | stop_r_set;
      stop_l_flag_r <= (stop_l_flag_r & ~stop_l_clr) | stop_l_set;
    end
  end

  // The stop request follows the switch level, so motion resumes on release.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      motor_stop_r <= 1'h0;
    end else begin
      motor_stop_r <= (stop_r_cond & ~move_dir_neg)
                    | (stop_l_cond & move_dir_neg)
                    | stall_halt_event_r;
    end
  end

  // Standstill wait, started when the velocity reaches zero.
  always_comb begin
    wait_cnt_nxt = wait_cnt_r;
    if (vzero & ~vzero_q_r) begin
      wait_cnt_nxt = standstill_wait_time_r;
    end else if (wait_cnt_r != 16'h0000) begin
      wait_cnt_nxt = wait_cnt_r - 16'h0001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wait_cnt_r <= 16'h0000;
      standstill_hold_r <= 1'h0;
    end else begin
      wait_cnt_r <= wait_cnt_nxt;
      standstill_hold_r <= (wait_cnt_nxt != 16'h0000);
    end
  end

  // Interrupt status, enable and clear.
  always_comb begin
    int_set = 7'h00;
    int_set[`INT_LATCH_L] = latch_l_set;
    int_set[`INT_LATCH_R] = latch_r_set;
    int_set[`INT_SECOND_MOVE] = second_move_pulse;
    int_set[`INT_POS] = pos_set;
    int_set[`INT_STALL] = stall_set & ~stall_halt_event_r;
    int_set[`INT_STOP_L] = stop_l_set & ~stop_l_flag_r;
    int_set[`INT_STOP_R] = stop_r_set & ~stop_r_flag_r;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_status_r <= `INT_RST;
    end else if (wr_en && (ph_addr_r == `OFS_INT_CLEAR)) begin
      int_status_r <= (int_status_r & ~hwdata[`INT_W-1:0]) | int_set;
    end else begin
      int_status_r <= int_status_r | int_set;
    end
  end

  // Position, stall and switch stop flags drive the line directly, regardless of the enable mask; the second move flag does not.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_r <= 1'h0;
    end else begin
      irq_r <= ev_pos_r
             | stall_halt_event_r
             | stop_l_flag_r | stop_r_flag_r
             | (|(int_status_r & int_enable_r));
    end
  end

  // Status word.
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`ST_STOP_L] = sw.active[0];
    status_word[`ST_STOP_R] = sw.active[1];
    status_word[`ST_LATCH_L] = latch_l_r;
    status_word[`ST_LATCH_R] = latch_r_r;
    status_word[`ST_STOP_L_FLAG] = stop_l_flag_r;
    status_word[`ST_STOP_R_FLAG] = stop_r_flag_r;
    status_word[`ST_STALL_HALT] = stall_halt_event_r;
    status_word[`ST_EV_POS] = ev_pos_r;
    status_word[`ST_VEL_REACHED] = vel_eq;
    status_word[`ST_POS_REACHED] = pos_eq;
    status_word[`ST_VZERO] = vzero;
    status_word[`ST_WAIT_ACTIVE] = standstill_hold_r;
    status_word[`ST_SECOND_MOVE] = second_move_r;
    status_word[`ST_STALL_LIVE] = stall_detect;
  end

  // Read data is fetched at the address phase, so it is ready with no wait state.
  always_comb begin
    rd_word = 32'h0000_0000;
    case (haddr[`ADDR_W-1:0])
      `OFS_SWITCH_CFG: begin
        rd_word[`CFG_W-1:0] = switch_mode_config_r;
      end
      `OFS_STATUS: begin
        rd_word = status_word;
      end
      `OFS_LATCH_POS: begin
        rd_word = latched_position_r;
      end
      `OFS_WAIT_TIME: begin
        rd_word[`WAIT_W-1:0] = standstill_wait_time_r;
      end
      `OFS_INT_STATUS: begin
        rd_word[`INT_W-1:0] = int_status_r;
      end
      `OFS_INT_ENABLE: begin
        rd_word[`INT_W-1:0] = int_enable_r;
      end
      default: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0000_0000;
    end else if (rd_take) begin
      hrdata_r <= rd_word;
    end
  end

  assign hreadyout = hreadyout_r;
  assign hresp = hresp_r;
  assign hrdata = hrdata_r;
  assign irq = irq_r;
  assign motor_stop = motor_stop_r;
  assign standstill_hold = standstill_hold_r;
endmodule

// ### pkg/rs_params.svh
`ifndef RS_PARAMS_SVH
`define RS_PARAMS_SVH

`define ADDR_W           8
`define HSIZE_WORD       3'h2
`define OFS_SWITCH_CFG   8'h00
`define OFS_STATUS       8'h04
`define OFS_LATCH_POS    8'h08
`define OFS_WAIT_TIME    8'h0c
`define OFS_INT_STATUS   8'h10
`define OFS_INT_CLEAR    8'h14
`define OFS_INT_ENABLE   8'h18

`define CFG_W            12
`define CFG_RST          12'h000
`define WAIT_W           16
`define WAIT_RST         16'h0000
`define INT_W            7
`define INT_RST          7'h00

`define SW_STOP_L_EN     0
`define SW_STOP_R_EN     1
`define SW_POL_L         2
`define SW_POL_R         3
`define SW_EXCHANGE      4
`define SW_LATCH_L_ACT   5
`define SW_LATCH_L_INACT 6
`define SW_LATCH_R_ACT   7
`define SW_LATCH_R_INACT 8
`define SW_STALL_HALT_EN 10

`define ST_STOP_L        0
`define ST_STOP_R        1
`define ST_LATCH_L       2
`define ST_LATCH_R       3
`define ST_STOP_L_FLAG   4
`define ST_STOP_R_FLAG   5
`define ST_STALL_HALT    6
`define ST_EV_POS        7
`define ST_VEL_REACHED   8
`define ST_POS_REACHED   9
`define ST_VZERO         10
`define ST_WAIT_ACTIVE   11
`define ST_SECOND_MOVE   12
`define ST_STALL_LIVE    13

`define INT_LATCH_L      0
`define INT_LATCH_R      1
`define INT_SECOND_MOVE  2
`define INT_POS          3
`define INT_STALL        4
`define INT_STOP_L       5
`define INT_STOP_R       6

`endif

// ### pkg/rs_pkg.sv
package rs_pkg;
  typedef logic [31:0] word_t;
  typedef logic [1:0]  side_t;
endpackage

// ### pkg/switch_if.sv
`timescale 1ns/1ps
interface switch_if;
  logic          exchange;
  logic          pol_l;
  logic          pol_r;
  rs_pkg::side_t active;
  rs_pkg::side_t act_edge;
  rs_pkg::side_t inact_edge;
  modport front (input exchange, input pol_l, input pol_r,
                 output active, output act_edge, output inact_edge);
  modport core  (output exchange, output pol_l, output pol_r,
                 input active, input act_edge, input inact_edge);
endinterface

// ### hw/switch_front.sv
`timescale 1ns/1ps
module switch_front (
  // Clock and reset.
  input  wire logic   hclk,
  input  wire logic   hresetn,
  // Raw switch pins.
  input  wire logic   left_switch_in,
  input  wire logic   right_switch_in,
  // Conditioned switch view, index 0 left, 1 right.
  switch_if.front     sw
);
  import rs_pkg::*;

  side_t meta_r;
  side_t sync_r;
  side_t level_r;
  side_t phys;
  side_t pol;
  side_t act;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_r <= 2'h0;
      sync_r <= 2'h0;
    end else begin
      meta_r <= {right_switch_in, left_switch_in};
      sync_r <= meta_r;
    end
  end

  assign pol = {sw.pol_r, sw.pol_l};

  // The previous active level makes each synchronised edge one pulse.
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_side
      assign phys[g] = sw.exchange ? sync_r[1-g] : sync_r[g];
      assign act[g] = phys[g] ^ pol[g];
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          level_r[g] <= 1'h0;
        end else begin
          level_r[g] <= act[g];
        end
      end
      assign sw.active[g] = act[g];
      assign sw.act_edge[g] = act[g] & ~level_r[g];
      assign sw.inact_edge[g] = ~act[g] & level_r[g];
    end
  endgenerate
endmodule

// ### tb/ref_switch_ramp_status_asserts.sv
`timescale 1ns/1ps
module rs_checker (
  // Clock, reset and bus.
  input wire logic          hclk,
  input wire logic          hresetn,
  input wire logic          hsel,
  input wire rs_pkg::word_t haddr,
  input wire logic [1:0]    htrans,
  input wire logic          hwrite,
  input wire logic [2:0]    hsize,
  input wire logic          hready,
  input wire rs_pkg::word_t hrdata,
  // Ramp state and outputs.
  input wire rs_pkg::word_t actual_position,
  input wire rs_pkg::word_t target_position,
  input wire rs_pkg::word_t actual_velocity,
  input wire rs_pkg::word_t max_velocity,
  input wire logic          stall_detect,
  input wire logic          second_move_pulse,
  input wire logic          standstill_hold,
  input wire logic          irq
);
  import rs_pkg::*;
  wire  rd   = hsel && htrans[1] && hready && !hwrite && hsize == 3'h2 && haddr[7:0] == 8'h04;
  wire  eq_p = actual_position == target_position;
  wire  eq_0 = actual_velocity == 32'h0;
  wire  eq_m = actual_velocity == max_velocity;
  logic pend_r;
  // A reversal seen since the last status read must show in the next one.
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      pend_r <= 1'b0;
    else
      pend_r <= second_move_pulse | (pend_r & !rd);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  pos_match_a: assert property (rd && $stable(eq_p) |=> hrdata[9] == $past(eq_p))
    else $error("position match bit wrong");
  vel_zero_a: assert property (rd && $stable(eq_0) |=> hrdata[10] == $past(eq_0))
    else $error("zero velocity bit wrong");
  vel_max_a: assert property (rd && $stable(eq_m) |=> hrdata[8] == $past(eq_m))
    else $error("velocity reached bit wrong");
  stall_live_a: assert property (rd && $stable(stall_detect) |=> hrdata[13] == $past(stall_detect))
    else $error("live stall bit wrong");
  wait_bit_a: assert property (rd |=> hrdata[11] == $past(standstill_hold))
    else $error("wait bit differs from hold output");
  hold_start_a: assert property ($rose(standstill_hold) |-> $past(eq_0))
    else $error("hold began while moving");
  second_flag_a: assert property (rd |=> hrdata[12] == $past(pend_r))
    else $error("reversal flag wrong");
  pos_irq_a: assert property ($rose(eq_p) |-> ##[1:4] irq)
    else $error("no interrupt on position reached");
endmodule

// ### tb/ref_switches.sv
`timescale 1ns/1ps
module ref_switches (
  // Commanded contact states.
  input  wire logic want_l,
  input  wire logic want_r,
  // Switch pins.
  output logic      left_switch_in,
  output logic      right_switch_in
);
  // Contacts move at times unrelated to the clock, as real switches do.
  initial {left_switch_in, right_switch_in} = 2'h0;
  always @(want_l) left_switch_in <= #7 want_l;
  always @(want_r) right_switch_in <= #13 want_r;
endmodule

// ### tb/tb_ref_switch_ramp_status.sv
`timescale 1ns/1ps
`include "rs_params.svh"
module tb_ref_switch_ramp_status;
  import rs_pkg::*;
  typedef struct packed {
    logic [11:0] cfg;
    logic [1:0]  pins;
    word_t       pa, pt, va, vm;
    logic        st;
    logic [13:0] exp;
  } row_s;
  logic       hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic       want_l = 1'b0, want_r = 1'b0, stall_detect = 1'b0, second_move_pulse = 1'b0;
  logic       ramp_hold_mode = 1'b0, move_dir_neg = 1'b0;
  logic       hreadyout, hresp, motor_stop, standstill_hold, irq, left_switch_in, right_switch_in;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  word_t      haddr = 32'h0, hwdata = 32'h0, hrdata, tmp;
  word_t      actual_position = 32'h0, target_position = 32'h0, actual_velocity = 32'h0, max_velocity = 32'h0;
  int         failures = 0, n_checks = 0;
  logic [7:0] radr[6] = '{`OFS_SWITCH_CFG, `OFS_LATCH_POS, `OFS_WAIT_TIME, `OFS_INT_STATUS, `OFS_INT_ENABLE, 8'h1c};
  // Pins are {right, left}; the expected word holds only the live status bits.
  row_s rows[6] = '{
    '{12'h000, 2'h0, 32'h5, 32'h5, 32'h0, 32'h9, 1'b0, 14'h0600},
    '{12'h000, 2'h1, 32'h5, 32'h6, 32'h9, 32'h9, 1'b1, 14'h2101},
    '{12'h00c, 2'h1, 32'h7, 32'h8, 32'h3, 32'h9, 1'b0, 14'h0002},
    '{12'h010, 2'h1, 32'hffff_ffff, 32'hffff_ffff, 32'h8000_0000, 32'h8000_0000, 1'b0, 14'h0302},
    '{12'h018, 2'h2, 32'h1, 32'h0, 32'h1, 32'h2, 1'b0, 14'h0003},
    '{12'h004, 2'h2, 32'h1, 32'h0, 32'h1, 32'h2, 1'b0, 14'h0003}
  };

  always #20 hclk = ~hclk;

  ref_switch_ramp_status i_ref_switch_ramp_status (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .left_switch_in(left_switch_in), .right_switch_in(right_switch_in),
    .actual_position(actual_position), .target_position(target_position),
    .actual_velocity(actual_velocity), .max_velocity(max_velocity), .stall_detect(stall_detect),
    .second_move_pulse(second_move_pulse), .ramp_hold_mode(ramp_hold_mode),
    .move_dir_neg(move_dir_neg), .motor_stop(motor_stop), .standstill_hold(standstill_hold), .irq(irq)
  );
  ref_switches i_ref_switches (
    .want_l(want_l), .want_r(want_r), .left_switch_in(left_switch_in), .right_switch_in(right_switch_in)
  );

  task automatic tally_and_finish();
    if (failures == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input word_t got, input word_t want);
    n_checks++;
    if (got !== want) begin
      failures++;
      $display("wrong value at %0t ns: got %h, expected %h", $time, got, want);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic rst();
    hresetn <= 1'b0;
    cyc(4);
    hresetn <= 1'b1;
    cyc(2);
  endtask
  // Waits are bounded so a stuck slave ends the run instead of hanging it.
  task automatic bus(input logic wr, input logic [7:0] a, input word_t wd, output word_t rd);
    int t;
    t = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do begin
      @(posedge hclk);
      t++;
    end while (hreadyout !== 1'b1 && t < 40);
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge hclk);
      t++;
    end while (hreadyout !== 1'b1 && t < 40);
    rd = hrdata;
    if (t >= 40) begin
      failures++;
      tally_and_finish();
    end
  endtask
  task automatic wr(input logic [7:0] a, input word_t d);
    word_t x;
    bus(1'b1, a, d, x);
  endtask
  task automatic rdc(input logic [7:0] a, input word_t m, input word_t e);
    word_t x;
    bus(1'b0, a, 32'h0, x);
    chk(x & m, e);
    chk(32'(hresp), 32'h0);
  endtask

  initial begin
    rst();
    foreach (rows[i]) begin
      wr(`OFS_SWITCH_CFG, {20'h0, rows[i].cfg});
      {want_r, want_l} <= rows[i].pins;
      actual_position <= rows[i].pa;
      target_position <= rows[i].pt;
      actual_velocity <= rows[i].va;
      max_velocity <= rows[i].vm;
      stall_detect <= rows[i].st;
      cyc(6);
      rdc(`OFS_STATUS, 32'h2703, {18'h0, rows[i].exp});
    end
    rst();
    wr(8'h1c, 32'hffff_ffff);
    foreach (radr[i]) rdc(radr[i], 32'hffff_ffff, 32'h0);
    wr(`OFS_SWITCH_CFG, 32'hffff_ffff);
    rdc(`OFS_SWITCH_CFG, 32'hffff_ffff, 32'hfff);
    // A transfer narrower than a word completes but must leave the register untouched.
    hsize <= 3'h0;
    wr(`OFS_SWITCH_CFG, 32'h0);
    hsize <= 3'h2;
    rdc(`OFS_SWITCH_CFG, 32'hffff_ffff, 32'hfff);
    wr(`OFS_SWITCH_CFG, 32'h0);
    {want_r, want_l} <= 2'h0;
    target_position <= 32'hffff_ffff;
    cyc(6);
    wr(`OFS_INT_CLEAR, 32'h7f);
    bus(1'b0, `OFS_STATUS, 32'h0, tmp);
    wr(`OFS_INT_ENABLE, 32'h3);
    for (int i = 0; i < 4; i++) begin
      wr(`OFS_SWITCH_CFG, 32'h20 << i);
      actual_position <= 32'ha0 + i;
      {want_r, want_l} <= (i < 2) ? 2'h1 : 2'h2;
      cyc(6);
      actual_position <= 32'hb0 + i;
      {want_r, want_l} <= 2'h0;
      cyc(6);
      rdc(`OFS_LATCH_POS, 32'hffff_ffff, (i[0] ? 32'hb0 : 32'ha0) + i);
      chk(32'(irq), 32'h1);
      rdc(`OFS_STATUS, 32'hc, (i < 2) ? 32'h4 : 32'h8);
      rdc(`OFS_STATUS, 32'hc, 32'h0);
      rdc(`OFS_INT_STATUS, 32'h7f, (i < 2) ? 32'h1 : 32'h2);
      wr(`OFS_INT_ENABLE, 32'h0);
      cyc(2);
      chk(32'(irq), 32'h0);
      wr(`OFS_INT_CLEAR, 32'h7f);
      wr(`OFS_INT_ENABLE, 32'h3);
      cyc(2);
      chk(32'(irq), 32'h0);
    end
    for (int i = 0; i < 2; i++) begin
      wr(`OFS_SWITCH_CFG, 32'h1 << i);
      move_dir_neg <= !i[0];
      {want_r, want_l} <= 2'h1 << i;
      cyc(6);
      chk(32'(motor_stop), 32'h1);
      {want_r, want_l} <= 2'h0;
      cyc(6);
      chk(32'(motor_stop), 32'h0);
      chk(32'(irq), 32'h1);
      rdc(`OFS_STATUS, 32'h30, 32'h10 << i);
      if (i == 0)
        ramp_hold_mode <= 1'b1;
      else
        move_dir_neg <= 1'b1;
      cyc(3);
      rdc(`OFS_STATUS, 32'h30, 32'h0);
      chk(32'(irq), 32'h0);
      ramp_hold_mode <= 1'b0;
    end
    wr(`OFS_SWITCH_CFG, 32'h400);
    stall_detect <= 1'b1;
    cyc(3);
    stall_detect <= 1'b0;
    cyc(3);
    chk(32'(motor_stop), 32'h1);
    chk(32'(irq), 32'h1);
    rdc(`OFS_STATUS, 32'h2040, 32'h40);
    cyc(2);
    chk(32'(motor_stop), 32'h0);
    rdc(`OFS_STATUS, 32'h40, 32'h0);
    second_move_pulse <= 1'b1;
    cyc(1);
    second_move_pulse <= 1'b0;
    cyc(2);
    rdc(`OFS_STATUS, 32'h1000, 32'h1000);
    rdc(`OFS_STATUS, 32'h1000, 32'h0);
    actual_position <= 32'h77;
    target_position <= 32'h77;
    cyc(6);
    chk(32'(irq), 32'h1);
    rdc(`OFS_STATUS, 32'h280, 32'h280);
    rdc(`OFS_STATUS, 32'h280, 32'h200);
    chk(32'(irq), 32'h0);
    wr(`OFS_WAIT_TIME, 32'h10);
    actual_velocity <= 32'h0;
    cyc(4);
    chk(32'(standstill_hold), 32'h1);
    rdc(`OFS_STATUS, 32'h800, 32'h800);
    cyc(30);
    chk(32'(standstill_hold), 32'h0);
    tally_and_finish();
  end
endmodule

bind ref_switch_ramp_status rs_checker i_rs_checker (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hready(hready), .hrdata(hrdata), .actual_position(actual_position),
  .target_position(target_position), .actual_velocity(actual_velocity), .max_velocity(max_velocity),
  .stall_detect(stall_detect), .second_move_pulse(second_move_pulse),
  .standstill_hold(standstill_hold), .irq(irq)
);
